// ===== ppo_output_pixel_clock_gen.sv
// Output pixel clock divider with programmable rising edge delay
`timescale 1ns/1ps
`default_nettype none
module ppo_output_pixel_clock_gen
  import ppo_pkg::*;
(
  input  wire logic i_clk_sys,  // System clock
  input  wire logic i_rst_n,    // Synchronised reset, active low
  ppo_pix_if.clkgen pix         // Divider control and outputs
);

  logic [PH_W-1:0] ph_q;
  logic [PH_W-1:0] last_q;
  logic [PH_W-1:0] rise_q;
  logic [PH_W-1:0] ph_d;
  logic [PH_W-1:0] last_d;
  logic [PH_W-1:0] rise_d;
  logic [2:0]      div_eff;
  logic [2:0]      dly_eff;
  logic            pclk_q;
  logic            wrap;

  // ***************************************************************
  // Period and edge placement
  // ***************************************************************
  // Zero divider runs as one; delay kept inside the high phase
  always_comb begin
    div_eff = (pix.div == 3'h0) ? 3'h1 : pix.div;
    dly_eff = (pix.dly >= div_eff) ? div_eff - 3'h1 : pix.dly;
    last_d  = PH_W'({div_eff, 1'b0} - 4'h1);
    rise_d  = PH_W'({1'b0, div_eff} + {1'b0, dly_eff});
    wrap    = (ph_q >= last_q);
    ph_d    = wrap ? '0 : ph_q + 1'b1;
  end

  // Phase counter, new settings taken at period end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q   <= '0;
      last_q <= 4'h1;
      rise_q <= 4'h1;
    end else begin
      ph_q <= ph_d;
      if (wrap) begin
        last_q <= last_d;
        rise_q <= rise_d;
      end
    end
  end

  // Clock falls with data change, rises div plus delay later
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= (ph_d >= rise_q);
    end
  end

  assign pix.adv  = wrap;
  assign pix.pclk = pclk_q;

  // Data change coincides with the falling edge
  AST_EDGE_FALL: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n) pix.adv |=> !pix.pclk)
    else $error("pixel clock not low after data change");

  // Default settings put the rise half a period after data change
  AST_HALF_PERIOD: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (pix.adv && last_q == 4'h1 && rise_q == 4'h1)
      |=> !pix.pclk ##1 pix.pclk)
    else $error("pixel clock rise not half a period after data");

endmodule : ppo_output_pixel_clock_gen
`default_nettype wire

// ===== ppo_pix_if.sv
// Interface between pixel clock generator and timing generator
`timescale 1ns/1ps
`default_nettype none
interface ppo_pix_if;
  logic       adv;   // Pixel advance, one cycle per pixel period
  logic       pclk;  // Output pixel clock level
  logic [2:0] div;   // Half period in system clocks
  logic [2:0] dly;   // Extra delay of rising edge
  modport clkgen (input div, dly, output adv, pclk);
  modport timing (output div, dly, input adv, pclk);
endinterface : ppo_pix_if
`default_nettype wire

// ===== ppo_pkg.sv
// Constants, register map and types of the parallel pixel output block
package ppo_pkg;

  // ***************************************************************
  // Register map (byte addresses, 16-bit registers high byte first)
  // ***************************************************************
  localparam int NCFG           = 12;
  localparam int CFG_ROW_SPEED  = 0;
  localparam int CFG_X_START    = 1;
  localparam int CFG_Y_START    = 2;
  localparam int CFG_X_END      = 3;
  localparam int CFG_Y_END      = 4;
  localparam int CFG_X_ODD_INC  = 5;
  localparam int CFG_Y_ODD_INC  = 6;
  localparam int CFG_LINE_LEN   = 7;
  localparam int CFG_FRAME_LEN  = 8;
  localparam int CFG_PROFILE    = 9;
  localparam int CFG_FORMAT     = 10;
  localparam int CFG_PAD_FUNC   = 11;

  localparam logic [15:0] CFG_ADDR [NCFG] = '{
    16'h3016, 16'h3100, 16'h3102, 16'h3104, 16'h3106, 16'h3108,
    16'h310a, 16'h310c, 16'h310e, 16'h306e, 16'h3110, 16'h3112};

  localparam logic [15:0] CFG_RST [NCFG] = '{
    16'h0001, 16'h0000, 16'h0000, 16'h063f, 16'h04af, 16'h0001,
    16'h0001, 16'h08d0, 16'h04c5, 16'h0000, 16'h0000, 16'h0000};

  localparam logic [15:0] ADDR_MODULE_ID  = 16'h0002;
  localparam logic [15:0] ADDR_PAD_STATUS = 16'h3027;
  localparam logic [15:0] ADDR_CAP_WIDTH  = 16'h3180;
  localparam logic [15:0] ADDR_CAP_HEIGHT = 16'h3182;
  localparam logic [15:0] CAP_WIDTH       = 16'h0640;
  localparam logic [15:0] CAP_HEIGHT      = 16'h04b0;

  // ***************************************************************
  // Field positions and encodings
  // ***************************************************************
  localparam int RS_DIV_LSB   = 0;
  localparam int RS_DLY_LSB   = 4;
  localparam int PROF_BIT     = 7;
  localparam int FMT_EIGHT_BIT_RAW_FORMAT_BIT = 0;
  localparam int ID_REV_LSB   = 3;
  localparam logic [6:0]  DEV_ADDR_LOW  = 7'h10;
  localparam logic [6:0]  DEV_ADDR_HIGH = 7'h18;
  localparam logic [15:0] ODD_INC_SKIP  = 16'h0003;

  // Frame start and end blanking in pixel clocks
  localparam logic [31:0] FSE_BLANK = 32'h0000_0006;

  // Divider phase counter width
  localparam int PH_W = 4;

  typedef enum logic [1:0] {
    PAD_ID      = 2'b00,
    PAD_STANDBY = 2'b01,
    PAD_OE_N    = 2'b10,
    PAD_TRIGGER = 2'b11
  } ppo_pad_fn_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FSTART = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_HBLANK = 3'b011,
    ST_FEND   = 3'b100,
    ST_VBLANK = 3'b101
  } ppo_state_type;

endpackage : ppo_pkg

// ===== ppo_rx_model.sv
// Receiver model that samples the pixel bus on the pixel clock
`timescale 1ns/1ps
`default_nettype none
module ppo_rx_model (
  input  wire logic       i_pclk,  // Pixel clock
  input  wire logic       i_lv,    // Row qualifier
  input  wire logic       i_fv,    // Frame qualifier
  input  wire logic [9:0] i_dout,  // Pixel bus
  output var int          o_front, // Periods frame start to first row
  output var int          o_act,   // Last active run
  output var int          o_row,   // Last row period
  output var int          o_rows,  // Rows seen
  output var int          o_bad    // Nonzero bus samples in blanking
);
  int   cnt = 0;
  int   last = 0;
  int   run = 0;
  logic lv_q = 0;
  logic fv_q = 0;
  // Rising edge sampling, half a period after the bus moves
  always @(posedge i_pclk) begin
    cnt = (i_fv && !fv_q) ? 0 : cnt + 1;
    if (!i_lv && lv_q) o_act = run;
    run = i_lv ? run + 1 : 0;
    if (i_lv && !lv_q) begin
      if (o_rows == 0) o_front = cnt;
      else o_row = cnt - last;
      last = cnt;
      o_rows++;
    end
    if (i_lv === 1'b0 && i_dout !== 10'h000) o_bad++;
    lv_q = i_lv;
    fv_q = i_fv;
  end
endmodule : ppo_rx_model
`default_nettype wire

// ===== ppo_timing.sv
// Parallel pixel output timing, pad functions and register file
`timescale 1ns/1ps
`default_nettype none
module ppo_timing
  import ppo_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h5,  // Arbitrary revision value
  parameter int          PAD_COUNT   = 4,     // Module ID pads
  parameter int          PIX_W       = 10     // Pixel bus width
)(
  input  wire logic [PAD_COUNT-1:0] i_module_id_inputs, // ID pads
  input  wire logic                 i_clk_sys,          // 125 MHz clock
  input  wire logic                 i_arst_n,           // Async reset
  input  wire logic                 i_addr_select,      // Address pin
  input  wire logic [7:0]           i_dev_addr,         // Address byte
  input  wire logic                 i_reg_wr,           // Write strobe
  input  wire logic                 i_reg_rd,           // Read strobe
  input  wire logic [15:0]          i_reg_addr,         // Byte address
  input  wire logic [7:0]           i_reg_wdata,        // Write byte
  input  wire logic [PIX_W-1:0]     i_pix_data,         // Array pixel
  output logic      [7:0]           o_reg_rdata,        // Read byte
  output logic                      o_dev_addr_hit,     // Address match
  output logic                      o_output_pixel_clock, // Pixel clock
  output logic                      o_row_qualifier_short,   // Row valid
  output logic                      o_frame_qualifier_short, // Frame
  output logic      [PIX_W-1:0]     o_dout,             // Pixel bus
  output logic                      o_pix_take,         // Pixel taken
  output logic                      o_out_en,           // Pads enabled
  output logic                      o_fmt_eight_bit_raw_format,         // Serial 8-bit
  output logic                      o_trigger           // Trigger pulse
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (PAD_COUNT != 4) begin : g_bad_pads
    $error("ID register layout needs exactly four pads");
  end
  if (PIX_W != 10) begin : g_bad_pix
    $error("pixel bus must be ten bits");
  end

  logic [1:0]           rst_s_q;
  logic                 rst_n;
  logic [PAD_COUNT-1:0] pad_s1_q;
  logic [PAD_COUNT-1:0] gpi_q;
  logic [PAD_COUNT-1:0] gpi_d_q;
  logic                 sel_s1_q;
  logic                 sel_q;
  logic [15:0]          cfg_q [NCFG];
  logic [7:0]           rd_d;
  logic [7:0]           id_byte;
  ppo_state_type        st_q;
  ppo_state_type        st_d;
  logic [31:0]          cnt_q;
  logic [31:0]          cnt_d;
  logic [31:0]          row_q;
  logic [31:0]          row_d;
  logic [31:0]          a_q;
  logic [31:0]          q_q;
  logic [31:0]          n_q;
  logic [31:0]          v_q;
  logic [31:0]          a_w;
  logic [31:0]          q_w;
  logic [31:0]          n_w;
  logic [31:0]          v_w;
  logic [31:0]          tot_w;
  logic [31:0]          fvt_w;
  logic [16:0]          wid_w;
  logic [16:0]          hgt_w;
  logic                 skip2;
  logic                 start_frame;
  logic                 standby;
  logic                 oe_block;
  logic                 trig_edge;
  logic [PAD_COUNT-1:0] pad_stby;
  logic [PAD_COUNT-1:0] pad_oe;
  logic [PAD_COUNT-1:0] pad_trig;

  ppo_pix_if pix ();

  // ***************************************************************
  // Reset and pin synchronisers
  // ***************************************************************
  // Assert at once, release on the clock
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s_q <= 2'b00;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  // Two flops on every pad input
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad_s1_q <= '0;
      gpi_q    <= '0;
      gpi_d_q  <= '0;
      sel_s1_q <= 1'b0;
      sel_q    <= 1'b0;
    end else begin
      pad_s1_q <= i_module_id_inputs;
      gpi_q    <= pad_s1_q;
      gpi_d_q  <= gpi_q;
      sel_s1_q <= i_addr_select;
      sel_q    <= sel_s1_q;
    end
  end

  // ***************************************************************
  // Pad functions
  // ***************************************************************
  for (genvar p = 0; p < PAD_COUNT; p++) begin : g_pad
    logic [1:0] fn;
    assign fn = cfg_q[CFG_PAD_FUNC][2*p +: 2];
    // Per pad function decode
    assign pad_stby[p] = (fn == PAD_STANDBY) && gpi_q[p];
    assign pad_oe[p]   = (fn == PAD_OE_N) && gpi_q[p];
    assign pad_trig[p] = (fn == PAD_TRIGGER) && gpi_q[p] &&
                         !gpi_d_q[p];
  end
  assign standby   = |pad_stby;
  assign oe_block  = |pad_oe;
  assign trig_edge = |pad_trig;

  // ***************************************************************
  // Register file
  // ***************************************************************
  for (genvar k = 0; k < NCFG; k++) begin : g_cfg
    // Byte writes into one 16-bit register
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q[k] <= CFG_RST[k];
      end else if (i_reg_wr && i_reg_addr[15:1] == CFG_ADDR[k][15:1]) begin
        if (i_reg_addr[0]) begin
          cfg_q[k][7:0] <= i_reg_wdata;
        end else begin
          cfg_q[k][15:8] <= i_reg_wdata;
        end
      end
    end
  end

  assign id_byte = {gpi_q[3], SILICON_REV, gpi_q[2:0]};

  // Read decode, unmapped bytes read zero
  always_comb begin
    rd_d = 8'h00;
    if (i_reg_addr == ADDR_MODULE_ID) begin
      rd_d = id_byte;
    end else if (i_reg_addr == ADDR_PAD_STATUS) begin
      rd_d = {4'h0, gpi_q};
    end else if (i_reg_addr[15:1] == ADDR_CAP_WIDTH[15:1]) begin
      rd_d = i_reg_addr[0] ? CAP_WIDTH[7:0] : CAP_WIDTH[15:8];
    end else if (i_reg_addr[15:1] == ADDR_CAP_HEIGHT[15:1]) begin
      rd_d = i_reg_addr[0] ? CAP_HEIGHT[7:0] : CAP_HEIGHT[15:8];
    end
    for (int k = 0; k < NCFG; k++) begin
      if (i_reg_addr[15:1] == CFG_ADDR[k][15:1]) begin
        rd_d = i_reg_addr[0] ? cfg_q[k][7:0] : cfg_q[k][15:8];
      end
    end
  end

  // Read data, device address match, format and trigger outputs
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata    <= 8'h00;
      o_dev_addr_hit <= 1'b0;
      o_fmt_eight_bit_raw_format     <= 1'b0;
      o_trigger      <= 1'b0;
      o_out_en       <= 1'b0;
    end else begin
      if (i_reg_rd) begin
        o_reg_rdata <= rd_d;
      end
      o_dev_addr_hit <= (i_dev_addr[7:1] ==
                         (sel_q ? DEV_ADDR_HIGH : DEV_ADDR_LOW));
      o_fmt_eight_bit_raw_format <= cfg_q[CFG_PROFILE][PROF_BIT] &&
                    cfg_q[CFG_FORMAT][FMT_EIGHT_BIT_RAW_FORMAT_BIT];
      o_trigger  <= trig_edge;
      o_out_en   <= !oe_block;
    end
  end

  // ***************************************************************
  // Pixel clock
  // ***************************************************************
  assign pix.div = cfg_q[CFG_ROW_SPEED][RS_DIV_LSB +: 3];
  assign pix.dly = cfg_q[CFG_ROW_SPEED][RS_DLY_LSB +: 3];

  ppo_output_pixel_clock_gen u_clkgen (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .pix       (pix.clkgen)
  );
  assign o_output_pixel_clock = pix.pclk;

  // ***************************************************************
  // Frame geometry
  // ***************************************************************
  always_comb begin
    skip2 = (cfg_q[CFG_X_ODD_INC] == ODD_INC_SKIP) &&
            (cfg_q[CFG_Y_ODD_INC] == ODD_INC_SKIP);
    wid_w = {1'b0, cfg_q[CFG_X_END]} - {1'b0, cfg_q[CFG_X_START]} + 17'h1;
    hgt_w = {1'b0, cfg_q[CFG_Y_END]} - {1'b0, cfg_q[CFG_Y_START]} + 17'h1;
    a_w   = 32'(wid_w >> skip2);
    n_w   = 32'(hgt_w >> skip2);
    if (a_w == 32'h0) a_w = 32'h1;
    if (n_w == 32'h0) n_w = 32'h1;
    q_w   = (32'(cfg_q[CFG_LINE_LEN]) > a_w) ?
            32'(cfg_q[CFG_LINE_LEN]) - a_w : 32'h1;
    tot_w = 32'(cfg_q[CFG_LINE_LEN]) * 32'(cfg_q[CFG_FRAME_LEN]);
    fvt_w = n_w * (a_w + q_w) - q_w + (FSE_BLANK << 1);
    v_w   = (tot_w > fvt_w) ? tot_w - fvt_w : 32'h1;
  end

  // ***************************************************************
  // Frame sequencer
  // ***************************************************************
  always_comb begin
    st_d  = st_q;
    cnt_d = (cnt_q == 32'h0) ? 32'h0 : cnt_q - 32'h1;
    row_d = row_q;
    unique case (st_q)
      ST_IDLE: begin
        if (!standby) begin
          st_d  = ST_FSTART;
          cnt_d = FSE_BLANK - 32'h1;
        end
      end
      ST_FSTART: begin
        if (cnt_q == 32'h0) begin
          st_d  = ST_ACTIVE;
          cnt_d = a_q - 32'h1;
          row_d = n_q - 32'h1;
        end
      end
      ST_ACTIVE: begin
        if (cnt_q == 32'h0) begin
          if (row_q == 32'h0) begin
            st_d  = ST_FEND;
            cnt_d = FSE_BLANK - 32'h1;
          end else begin
            st_d  = ST_HBLANK;
            cnt_d = q_q - 32'h1;
          end
        end
      end
      ST_HBLANK: begin
        if (cnt_q == 32'h0) begin
          st_d  = ST_ACTIVE;
          cnt_d = a_q - 32'h1;
          row_d = row_q - 32'h1;
        end
      end
      ST_FEND: begin
        if (cnt_q == 32'h0) begin
          st_d  = ST_VBLANK;
          cnt_d = v_q - 32'h1;
        end
      end
      ST_VBLANK: begin
        if (cnt_q == 32'h0) begin
          st_d  = standby ? ST_IDLE : ST_FSTART;
          cnt_d = FSE_BLANK - 32'h1;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 32'h0;
      end
    endcase
    start_frame = (st_d == ST_FSTART) && (st_q != ST_FSTART);
  end

  // Sequencer state, one step per pixel period
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_IDLE;
      cnt_q <= 32'h0;
      row_q <= 32'h0;
    end else if (pix.adv) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      row_q <= row_d;
    end
  end

  // Geometry held for the whole frame
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 32'h1;
      q_q <= 32'h1;
      n_q <= 32'h1;
      v_q <= 32'h1;
    end else if (pix.adv && start_frame) begin
      a_q <= a_w;
      q_q <= q_w;
      n_q <= n_w;
      v_q <= v_w;
    end
  end

  // Pixel bus and qualifiers change with the pixel clock fall
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_row_qualifier_short   <= 1'b0;
      o_frame_qualifier_short <= 1'b0;
      o_dout                  <= '0;
      o_pix_take              <= 1'b0;
    end else begin
      o_pix_take <= pix.adv && (st_d == ST_ACTIVE);
      if (pix.adv) begin
        o_row_qualifier_short   <= (st_d == ST_ACTIVE);
        o_frame_qualifier_short <= (st_d != ST_IDLE) &&
                                   (st_d != ST_VBLANK);
        o_dout <= (st_d == ST_ACTIVE) ?
                  i_pix_data : '0;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic [31:0] lv_run_q;
  logic [31:0] row_per_q;
  logic [31:0] l_q;

  // Active run length and row period, counted in pixel periods
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lv_run_q  <= 32'h0;
      row_per_q <= 32'h0;
      l_q       <= 32'h0;
    end else if (pix.adv) begin
      lv_run_q  <= (st_d == ST_ACTIVE) ?
                   ((st_q == ST_ACTIVE) ? lv_run_q + 32'h1 : 32'h1) : 32'h0;
      row_per_q <= (st_d == ST_ACTIVE && st_q != ST_ACTIVE) ?
                   32'h1 : row_per_q + 32'h1;
      if (start_frame) begin
        l_q <= a_w + q_w;
      end
    end
  end

  AST_ID_LAYOUT: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    (i_reg_rd && i_reg_addr == ADDR_MODULE_ID) |=> o_reg_rdata ==
      $past(id_byte))
    else $error("module ID byte layout wrong");

  AST_DEV_ADDR: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    (i_dev_addr[7:1] == (sel_q ? DEV_ADDR_HIGH : DEV_ADDR_LOW))
      |=> o_dev_addr_hit)
    else $error("device address not answered");

  AST_RESET_QUIET: assert property (@(posedge i_clk_sys)
    !rst_n |-> !o_frame_qualifier_short && !o_row_qualifier_short &&
      o_dout == '0)
    else $error("pixel output active during reset");

  AST_BLANK_ZERO: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) !o_row_qualifier_short |-> o_dout == '0)
    else $error("pixel bus not zero in blanking");

  AST_OUTPUT_PIXEL_CLOCK_RUNS: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n) !o_output_pixel_clock |-> ##[1:14]
      o_output_pixel_clock)
    else $error("pixel clock stopped");

  AST_EDGE_BLANK: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    (pix.adv && st_q == ST_FSTART && st_d == ST_ACTIVE) |->
      cnt_q == 32'h0 && o_frame_qualifier_short && !o_row_qualifier_short)
    else $error("frame edge blanking wrong");

  AST_ACTIVE_LEN: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    (pix.adv && st_q == ST_ACTIVE && st_d != ST_ACTIVE) |->
      lv_run_q == a_q)
    else $error("row qualifier length wrong");

  AST_ROW_PERIOD: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    (pix.adv && st_q == ST_HBLANK && st_d == ST_ACTIVE) |->
      row_per_q == l_q)
    else $error("row period wrong");

  AST_PROFILE0: assert property (@(posedge i_clk_sys)
    $rose(rst_n) |-> !cfg_q[CFG_PROFILE][PROF_BIT] && !o_fmt_eight_bit_raw_format)
    else $error("not profile 0 after reset");

  AST_EIGHT_BIT_RAW_FORMAT_GATE: assert property (@(posedge i_clk_sys)
    disable iff (!rst_n)
    o_fmt_eight_bit_raw_format |-> $past(cfg_q[CFG_PROFILE][PROF_BIT]))
    else $error("eight-bit format outside profile 1/2");

endmodule : ppo_timing
`default_nettype wire

// ===== ppo_timing_test.sv
// Self-checking bench of the parallel pixel output block
`timescale 1ns/1ps
`default_nettype none
module ppo_timing_test;
  import ppo_pkg::*;
  logic       clk = 0, rst_n = 0, sel = 0, wr = 0, rd = 0;
  logic [3:0] pads = 4'h0;
  logic [7:0] dev = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] addr = 16'h0000;
  logic [9:0] pix = 10'h000, dout, pix_q, q[$];
  logic       pclk, lv, fv, hit, take, eight_bit_raw_format, oen, trig;
  int seed = 49356, failures = 0, n_checks = 0, cyc = 0, k;
  int front, act, row, rows, bad;
  always #4 clk = ~clk;
  ppo_timing ppo_timing_inst (.i_module_id_inputs(pads), .i_clk_sys(clk),
    .i_arst_n(rst_n), .i_addr_select(sel), .i_dev_addr(dev),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_pix_data(pix), .o_reg_rdata(rdata), .o_dev_addr_hit(hit),
    .o_output_pixel_clock(pclk), .o_row_qualifier_short(lv),
    .o_frame_qualifier_short(fv), .o_dout(dout), .o_pix_take(take),
    .o_out_en(oen), .o_fmt_eight_bit_raw_format(eight_bit_raw_format), .o_trigger(trig));
  ppo_rx_model ppo_rx_model_inst (.i_pclk(pclk), .i_lv(lv), .i_fv(fv),
    .i_dout(dout), .o_front(front), .o_act(act), .o_row(row),
    .o_rows(rows), .o_bad(bad));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 0;
    rd = 0;
  endtask : acc
  task results;
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Random pixels from the array, and the pixels the device takes
  always @(posedge clk) #1 pix = 10'($random(seed));
  // The design took the pixel one edge before take shows
  always @(posedge clk) begin
    if (take === 1'b1) q.push_back(pix_q);
    pix_q = pix;
  end
  // Each sampled pixel must be the next one taken
  always @(posedge pclk) if (lv === 1'b1) begin
    if (q.size() > 0) chk(16'(dout), 16'(q.pop_front()));
    else chk(16'h0001, 16'h0000);
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  // Main sequence
  initial begin
    pads = 4'($random(seed));
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    acc(0, ADDR_MODULE_ID, 0);
    chk(16'(rdata), {8'h00, pads[3], 4'h5, pads[2:0]});
    acc(0, ADDR_CAP_WIDTH + 16'h0001, 0);
    chk(16'(rdata), 16'h0040);
    acc(0, 16'h1234, 0);
    chk(16'(rdata), 16'h0000);
    acc(1, 16'h3111, 8'h01);
    repeat (3) @(posedge clk);
    chk(16'(eight_bit_raw_format), 16'h0000);
    acc(1, 16'h306f, 8'h80);
    repeat (3) @(posedge clk);
    chk(16'(eight_bit_raw_format), 16'h0001);
    // Pad 0 as output disable, pad 1 as trigger
    acc(1, 16'h3113, 8'h0e);
    pads = 4'h0;
    repeat (3) @(posedge clk);
    #1 chk(16'(oen), 16'h0001);
    pads = 4'h1;
    repeat (3) @(posedge clk);
    #1 chk(16'(oen), 16'h0000);
    pads = 4'h3;
    repeat (3) @(posedge clk);
    #1 chk(16'(trig), 16'h0001);
    @(posedge clk);
    #1 chk(16'(trig), 16'h0000);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      #1 sel = k[1];
      dev = k[0] ? 8'h30 : 8'h21;
      repeat (5) @(posedge clk);
      chk(16'(hit), 16'(k[0] == k[1]));
    end
    k = 0;
    while (rows < 3 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk(16'(front), 16'd6);
    chk(16'(act), 16'd1600);
    chk(16'(row), 16'd2256);
    chk(16'(row - act), 16'd656);
    chk(16'(bad), 16'd0);
    // Reset in mid-frame stops the output and restores defaults
    #1 rst_n = 0;
    @(posedge clk);
    #1 chk(16'({lv, fv, pclk, dout}), 16'h0000);
    rst_n = 1;
    repeat (4) @(posedge clk);
    acc(0, 16'h306f, 0);
    chk(16'(rdata), 16'h0000);
    chk(16'(eight_bit_raw_format), 16'h0000);
    results();
  end
endmodule : ppo_timing_test
`default_nettype wire
